/* rtl/link_reply_framer.sv */
// Reply framer building accept and reject frames for switch service requests
`timescale 1ns/100ps
`default_nettype none
module link_reply_framer (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic [31:0]                  req_cmd,
  input  wire logic [23:0]                  req_sid,
  input  wire logic [23:0]                  req_did,
  input  wire logic                         req_accept,
  input  wire logic [23:0]                  acc_param,
  input  wire link_reply_pkg::rej_cause_t   rej_cause,
  input  wire link_reply_pkg::expl_cause_t  expl_cause,
  input  wire logic [3:0]                   expl_detail,
  input  wire logic [7:0]                   vendor_code,
  input  wire logic                         port_invalid_attach,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [31:0]                       out_data,
  output logic                              out_last,
  output logic                              no_reply
);
  import link_reply_pkg::*;

  // ****************************************************************
  // Encoding functions
  // ****************************************************************

  // Reason code from the refusal cause; invalid attachment overrides all
  function automatic logic [7:0] reason_encode(input rej_cause_t c, input logic att);
    logic [7:0] r;
    r = RSN_UNABLE;
    if (att) begin
      r = RSN_INVALID_ATT;
    end else begin
      case (c)
        CAUSE_UNKNOWN_CMD:  r = RSN_UNKNOWN_CMD;
        CAUSE_UNSUPPORTED:  r = RSN_UNSUPPORTED;
        CAUSE_BAD_REVISION: r = RSN_BAD_REVISION;
        CAUSE_LOGICAL:      r = RSN_LOGICAL;
        CAUSE_BAD_SIZE:     r = RSN_BAD_SIZE;
        CAUSE_BUSY:         r = RSN_BUSY;
        CAUSE_PROTOCOL:     r = RSN_PROTOCOL;
        CAUSE_VENDOR:       r = RSN_VENDOR;
        default:            r = RSN_UNABLE;
      endcase
    end
    return r;
  endfunction

  // Explanation byte; unknown causes fall back to no explanation
  function automatic logic [7:0] expl_encode(input expl_cause_t c, input logic [3:0] d);
    logic [7:0] e;
    e = EXP_NONE;
    case (c)
      EXPL_CLASS_F:     e = EXP_CLASS_F;
      EXPL_CLASS_N:     e = EXP_CLASS_N;
      EXPL_IN_PROGRESS: e = EXP_IN_PROGRESS;
      EXPL_LINK_NOT_UP: e = EXP_LINK_NOT_UP;
      EXPL_SECURITY:    e = {EXP_SECURITY_HI, d};
      EXPL_ZONING:      e = {EXP_ZONING_HI, d};
      EXPL_NO_VERIFY:   e = EXP_NO_VERIFY;
      EXPL_NO_TXN:      e = EXP_NO_TXN;
      EXPL_BAD_PHASE:   e = EXP_BAD_PHASE;
      EXPL_ADV_PHASE:   e = EXP_ADV_PHASE;
      default:          e = EXP_NONE;
    endcase
    return e;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  frame_state_t     state;          // Framer state
  frame_state_t     next_state;
  logic [23:0]      cap_sid;        // Request source identifier
  logic [23:0]      next_cap_sid;
  logic [23:0]      cap_did;        // Request destination identifier
  logic [23:0]      next_cap_did;
  logic             cap_accept;     // Reply kind, high for accept
  logic             next_cap_accept;
  logic [23:0]      cap_param;      // Accept first word low bytes
  logic [23:0]      next_cap_param;
  logic [7:0]       cap_reason;     // Encoded reason code
  logic [7:0]       next_cap_reason;
  logic [7:0]       cap_expl;       // Encoded explanation
  logic [7:0]       next_cap_expl;
  logic [7:0]       cap_vendor;     // Vendor byte, zero unless vendor error
  logic [7:0]       next_cap_vendor;
  logic             next_no_reply;
  logic             silent_cmd;     // Request that never gets a reply
  logic             take;           // Request taken this cycle
  logic             push;           // Word written into buffer
  logic [31:0]      push_data;
  logic             push_last;
  logic             buf_in_ready;   // Buffer has a free entry
  logic [32:0]      buf_mem [0:BUF_DEPTH-1];  // Entries: last flag and word
  logic [32:0]      next_buf_mem [0:BUF_DEPTH-1];
  logic             wr_ptr;
  logic             next_wr_ptr;
  logic             rd_ptr;
  logic             next_rd_ptr;
  logic [1:0]       buf_count;
  logic [1:0]       next_buf_count;
  logic             pop;

  // ****************************************************************
  // Request intake and framer
  // ****************************************************************

  // Hello and link state frames are consumed without any reply
  assign silent_cmd = (req_cmd == CMD_HELLO) || (req_cmd == CMD_LS_UPDATE) ||
                      (req_cmd == CMD_LS_ACK);
  assign req_ready  = (state == S_IDLE);
  assign take       = req_valid && req_ready;
  assign push       = (state != S_IDLE) && buf_in_ready;

  // Word selection per state
  always_comb begin
    push_data = 32'h0000_0000;
    push_last = 1'b0;
    case (state)
      S_HDR0: push_data = {RCTL_REPLY, cap_sid};
      S_HDR1: push_data = {CS_CTL_VALUE, cap_did};
      S_HDR2: push_data = {FRAME_TYPE_SWITCH, 24'h00_0000};
      S_PAY0: begin
        if (cap_accept) begin
          push_data = {ACC_CMD_BYTE, cap_param};
          push_last = 1'b1;
        end else begin
          push_data = RJT_WORD;
        end
      end
      S_PAY1: begin
        push_data = {RESERVED_BYTE, cap_reason, cap_expl, cap_vendor};
        push_last = 1'b1;
      end
      default: push_data = 32'h0000_0000;
    endcase
  end

  // Next state and captured request fields
  always_comb begin
    next_state      = state;
    next_cap_sid    = cap_sid;
    next_cap_did    = cap_did;
    next_cap_accept = cap_accept;
    next_cap_param  = cap_param;
    next_cap_reason = cap_reason;
    next_cap_expl   = cap_expl;
    next_cap_vendor = cap_vendor;
    next_no_reply   = 1'b0;
    case (state)
      S_IDLE: begin
        if (take && silent_cmd) begin
          next_no_reply = 1'b1;
        end else if (take) begin
          next_state      = S_HDR0;
          next_cap_sid    = req_sid;
          next_cap_did    = req_did;
          next_cap_accept = req_accept && !port_invalid_attach;
          next_cap_param  = acc_param;
          next_cap_reason = reason_encode(rej_cause, port_invalid_attach);
          next_cap_expl   = expl_encode(expl_cause, expl_detail);
          next_cap_vendor = (!port_invalid_attach && rej_cause == CAUSE_VENDOR) ?
                            vendor_code : RESERVED_BYTE;
        end
      end
      S_HDR0: if (push) next_state = S_HDR1;
      S_HDR1: if (push) next_state = S_HDR2;
      S_HDR2: if (push) next_state = S_PAY0;
      S_PAY0: if (push) next_state = cap_accept ? S_IDLE : S_PAY1;
      S_PAY1: if (push) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // Framer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= S_IDLE;
      cap_sid    <= 24'h00_0000;
      cap_did    <= 24'h00_0000;
      cap_accept <= 1'b0;
      cap_param  <= 24'h00_0000;
      cap_reason <= 8'h00;
      cap_expl   <= 8'h00;
      cap_vendor <= 8'h00;
      no_reply   <= 1'b0;
    end else begin
      state      <= next_state;
      cap_sid    <= next_cap_sid;
      cap_did    <= next_cap_did;
      cap_accept <= next_cap_accept;
      cap_param  <= next_cap_param;
      cap_reason <= next_cap_reason;
      cap_expl   <= next_cap_expl;
      cap_vendor <= next_cap_vendor;
      no_reply   <= next_no_reply;
    end
  end

  // ****************************************************************
  // Two-entry output buffer
  // ****************************************************************
  assign buf_in_ready = (buf_count != 2'(BUF_DEPTH));
  assign out_valid    = (buf_count != 2'h0);
  assign pop          = out_valid && out_ready;
  assign out_data     = buf_mem[rd_ptr][31:0];
  assign out_last     = buf_mem[rd_ptr][32];

  // Pointer, count and entry updates
  always_comb begin
    next_buf_mem = buf_mem;
    next_wr_ptr  = wr_ptr;
    next_rd_ptr  = rd_ptr;
    next_buf_count = buf_count;
    if (push) begin
      next_buf_mem[wr_ptr] = {push_last, push_data};
      next_wr_ptr          = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_buf_count = buf_count + 2'h1;
    end else if (pop && !push) begin
      next_buf_count = buf_count - 2'h1;
    end
  end

  // Buffer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_mem[0] <= 33'h0_0000_0000;
      buf_mem[1] <= 33'h0_0000_0000;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      buf_count  <= BUF_COUNT_RESET;
    end else begin
      buf_mem    <= next_buf_mem;
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      buf_count  <= next_buf_count;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reply request accepted, then its header starts
  sequence s_reply_taken;
    take && !silent_cmd;
  endsequence
  sequence s_header_walk;
    (state == S_HDR0) ##[1:8] (state == S_HDR1);
  endsequence

  a_reply_start: assert property (s_reply_taken |=> s_header_walk)
    else $error("Reply header did not start after request");
  a_silent_req: assert property (take && silent_cmd |=> no_reply && state == S_IDLE)
    else $error("Reply started for a request that takes none");
  // Identifiers come from the request just taken, not from stale captures
  a_hdr_swap: assert property (s_reply_taken |=>
      cap_sid == $past(req_sid) && cap_did == $past(req_did) &&
      push_data == {RCTL_REPLY, cap_sid})
    else $error("Reply destination or routing control wrong");
  a_hdr_type: assert property (push && state == S_HDR2 |->
      push_data[31:24] == FRAME_TYPE_SWITCH)
    else $error("Reply frame type wrong");
  a_acc_word: assert property (push && state == S_PAY0 && cap_accept |->
      push_data[31:24] == ACC_CMD_BYTE && push_last)
    else $error("Accept first word wrong");
  a_rjt_word: assert property (push && state == S_PAY0 && !cap_accept |->
      push_data == RJT_WORD ##[1:8] (push && state == S_PAY1))
    else $error("Reject payload sequence wrong");
  a_attach_reason: assert property (take && !silent_cmd && port_invalid_attach |=>
      !cap_accept && cap_reason == RSN_INVALID_ATT)
    else $error("Invalid attachment reason missing");
  a_vendor_zero: assert property (push && state == S_PAY1 &&
      cap_reason != RSN_VENDOR |-> push_data[7:0] == 8'h00 && push_data[31:24] == 8'h00)
    else $error("Reserved reject bytes not zero");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Output word changed while stalled");

endmodule
`default_nettype wire

/* rtl/link_reply_pkg.sv */
// Constants, encodings and state types for the link service reply framer
// Overview of operation
// - Accept on completion, reject on refusal
// - Accept payload first word top byte 02h
// - No reply to hello or link state frames
// - Swap request source and destination identifiers
// - Reject payload: 01000000h, reserved, reason, explanation, vendor
// - Reason 01h unknown, 0Bh unsupported command
// - Reason 02h for unsupported revision level
// - Reason 03h for logical error
// - Reason 04h for payload size mismatch
// - Reason 05h when recipient busy
// - Reason 07h for protocol violation
// - Reason 09h when otherwise unable
// - Reason 0Ch in invalid attachment state
// - Vendor byte meaningful only with reason FFh
// - Explanation 00h none, 01h class F, 03h class N
// - Explanation 19h command already in progress
// - Explanation 2Dh link parameters not established
// - Explanations 30h-3Fh form the security group
// - Explanations 40h-4Fh form the zoning group
// - Explanation 50h cannot verify connection
// - Explanation 59h, 5Ah, 5Bh for transaction faults
// - Routing control 02h requests, 03h replies
// - Frame type 22h on every service frame
package link_reply_pkg;

  // ****************************************************************
  // Frame header constants
  // ****************************************************************
  localparam logic [7:0]  RCTL_REQUEST      = 8'h02;   // Routing control, request
  localparam logic [7:0]  RCTL_REPLY        = 8'h03;   // Routing control, reply
  localparam logic [7:0]  FRAME_TYPE_SWITCH = 8'h22;   // Fabric switch services type
  localparam logic [7:0]  CS_CTL_VALUE      = 8'h00;   // Class control byte
  localparam logic [7:0]  RESERVED_BYTE     = 8'h00;   // Reserved bytes sent as zero

  // ****************************************************************
  // Command words
  // ****************************************************************
  localparam logic [7:0]  ACC_CMD_BYTE      = 8'h02;         // Accept top byte
  localparam logic [31:0] RJT_WORD          = 32'h0100_0000; // Reject first word
  localparam logic [31:0] CMD_HELLO         = 32'h1400_0000; // hello_request
  localparam logic [31:0] CMD_LS_UPDATE     = 32'h1500_0000; // link_state_update_req
  localparam logic [31:0] CMD_LS_ACK        = 32'h1600_0000; // link_state_ack_req

  // ****************************************************************
  // Reason codes
  // ****************************************************************
  localparam logic [7:0]  RSN_UNKNOWN_CMD   = 8'h01;
  localparam logic [7:0]  RSN_BAD_REVISION  = 8'h02;
  localparam logic [7:0]  RSN_LOGICAL       = 8'h03;
  localparam logic [7:0]  RSN_BAD_SIZE      = 8'h04;
  localparam logic [7:0]  RSN_BUSY          = 8'h05;
  localparam logic [7:0]  RSN_PROTOCOL      = 8'h07;
  localparam logic [7:0]  RSN_UNABLE        = 8'h09;
  localparam logic [7:0]  RSN_UNSUPPORTED   = 8'h0B;
  localparam logic [7:0]  RSN_INVALID_ATT   = 8'h0C;
  localparam logic [7:0]  RSN_VENDOR        = 8'hFF;

  // ****************************************************************
  // Reason code explanations
  // ****************************************************************
  localparam logic [7:0]  EXP_NONE          = 8'h00;
  localparam logic [7:0]  EXP_CLASS_F       = 8'h01;
  localparam logic [7:0]  EXP_CLASS_N       = 8'h03;
  localparam logic [7:0]  EXP_IN_PROGRESS   = 8'h19;
  localparam logic [7:0]  EXP_LINK_NOT_UP   = 8'h2D;
  localparam logic [3:0]  EXP_SECURITY_HI   = 4'h3;    // Security group 30h-3Fh
  localparam logic [3:0]  EXP_ZONING_HI     = 4'h4;    // Zoning group 40h-4Fh
  localparam logic [7:0]  EXP_NO_VERIFY     = 8'h50;
  localparam logic [7:0]  EXP_NO_TXN        = 8'h59;
  localparam logic [7:0]  EXP_BAD_PHASE     = 8'h5A;
  localparam logic [7:0]  EXP_ADV_PHASE     = 8'h5B;

  // ****************************************************************
  // Buffer geometry and reset values
  // ****************************************************************
  localparam int          WORD_W            = 32;      // Stream word width
  localparam int          BUF_DEPTH         = 2;       // Output buffer entries
  localparam logic [1:0]  BUF_COUNT_RESET   = 2'h0;

  // Refusal causes given by the request checker
  typedef enum logic [3:0] {
    CAUSE_UNKNOWN_CMD, CAUSE_UNSUPPORTED, CAUSE_BAD_REVISION, CAUSE_LOGICAL,
    CAUSE_BAD_SIZE, CAUSE_BUSY, CAUSE_PROTOCOL, CAUSE_UNABLE, CAUSE_VENDOR
  } rej_cause_t;

  // Explanation causes; group causes take a low nibble from the detail input
  typedef enum logic [3:0] {
    EXPL_NONE, EXPL_CLASS_F, EXPL_CLASS_N, EXPL_IN_PROGRESS, EXPL_LINK_NOT_UP,
    EXPL_SECURITY, EXPL_ZONING, EXPL_NO_VERIFY, EXPL_NO_TXN, EXPL_BAD_PHASE,
    EXPL_ADV_PHASE
  } expl_cause_t;

  // Framer states: idle, then one per emitted word
  typedef enum logic [2:0] {
    S_IDLE, S_HDR0, S_HDR1, S_HDR2, S_PAY0, S_PAY1
  } frame_state_t;

endpackage

/* test/reply_sink.sv */
// Reply stream sink standing in for the peer switch link service controller
`timescale 1ns/100ps
`default_nettype none
module reply_sink (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        out_last,
  input  wire logic        stall,
  input  wire logic        slow,
  output logic             out_ready
);
  // ****************************************************************
  // Flow control and capture
  // ****************************************************************
  logic        phase = 1'b0;  // Alternates each cycle for the slow mode
  logic [32:0] words[$];      // Received words with their last flag on top

  // Ready follows the stall input at once; the phase flips only after a rising edge
  assign out_ready = rst_n & ~stall & (~slow | phase);

  // Phase for taking a word every other cycle
  always @(posedge clk) begin
    phase <= ~phase;
  end

  // Store every word moved, raw; vendor and group bytes are judged by the bench
  always @(posedge clk) begin
    if (rst_n && out_valid && out_ready) begin
      words.push_back({out_last, out_data});
    end
  end
endmodule
`default_nettype wire

/* test/switch_link_service_reply_framer_tb.sv */
// Self-checking bench for the link service reply framer
`timescale 1ns/100ps
`default_nettype none
module switch_link_service_reply_framer_tb;
  import link_reply_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic [31:0] req_cmd = 32'h0;
  logic [23:0] sid = 24'h0;
  logic [23:0] did = 24'h0;
  logic        req_accept = 1'b0;
  logic [23:0] acc_param = 24'h0;
  rej_cause_t  rc = CAUSE_UNKNOWN_CMD;
  expl_cause_t ec = EXPL_NONE;
  logic [3:0]  det = 4'h0;
  logic [7:0]  vend = 8'h0;
  logic        inv = 1'b0;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic        req_ready;
  logic        out_valid;
  logic        out_ready;
  logic [31:0] out_data;
  logic        out_last;
  logic        no_reply;
  int          num_errors = 0;
  int          checks = 0;

  // Clock of 25 ns
  always #12.5 clk = ~clk;

  link_reply_framer dut_u (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_cmd(req_cmd), .req_sid(sid), .req_did(did), .req_accept(req_accept),
    .acc_param(acc_param), .rej_cause(rc), .expl_cause(ec), .expl_detail(det),
    .vendor_code(vend), .port_invalid_attach(inv), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last), .no_reply(no_reply)
  );

  reply_sink sink_u (
    .clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .stall(stall), .slow(slow), .out_ready(out_ready)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Count and compare one value
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Offer one request once the framer is idle, held over one rising edge
  task automatic send_req(input logic [31:0] cmd, input logic acc);
    int k;
    k = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    check({32'h0, req_ready}, 33'h1);
    req_cmd = cmd;
    req_accept = acc;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  // Wait for a whole reply and compare header, payload and last flags
  task automatic expect_frame(input logic [31:0] w3, input logic [31:0] w4, input int n);
    logic [32:0] exp [5];
    int          k;
    exp = '{{1'b0, RCTL_REPLY, sid}, {1'b0, CS_CTL_VALUE, did},
            {1'b0, FRAME_TYPE_SWITCH, 24'h0}, {n == 4, w3}, {1'b1, w4}};
    k = 0;
    while (sink_u.words.size() < n && k < 200) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
    check(33'(sink_u.words.size()), 33'(n));
    for (int i = 0; i < n; i++) begin
      check(sink_u.words[i], exp[i]);
    end
    sink_u.words.delete();
  endtask

  // Print counts and the verdict, then end the run
  task automatic stop_test;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Accept reply with swapped identifiers
  task automatic test_accept;
    sid = 24'h0A0B0C;
    did = 24'hFFFC01;
    acc_param = 24'h123456;
    send_req(32'h1000_0000, 1'b1);
    expect_frame({ACC_CMD_BYTE, acc_param}, 32'h0, 4);
    $display("test_accept done");
  endtask

  // Every refusal cause and explanation cause, vendor byte only with FFh
  task automatic test_reject_codes;
    logic [7:0] rsn [9];
    logic [7:0] expl [11];
    logic [7:0] e;
    logic [31:0] w;
    rsn = '{RSN_UNKNOWN_CMD, RSN_UNSUPPORTED, RSN_BAD_REVISION, RSN_LOGICAL,
            RSN_BAD_SIZE, RSN_BUSY, RSN_PROTOCOL, RSN_UNABLE, RSN_VENDOR};
    expl = '{EXP_NONE, EXP_CLASS_F, EXP_CLASS_N, EXP_IN_PROGRESS, EXP_LINK_NOT_UP,
             8'h00, 8'h00, EXP_NO_VERIFY, EXP_NO_TXN, EXP_BAD_PHASE, EXP_ADV_PHASE};
    for (int i = 0; i < 11; i++) begin
      rc = rej_cause_t'(i % 9);
      ec = expl_cause_t'(i);
      det = 4'(i + 7);
      vend = 8'hA5;
      sid = 24'h010200 + 24'(i);
      did = 24'hFFFFFD;
      e = (i == 5) ? {EXP_SECURITY_HI, det} :
          (i == 6) ? {EXP_ZONING_HI, det} : expl[i];
      w = {RESERVED_BYTE, rsn[i % 9], e, (i % 9 == 8) ? vend : 8'h00};
      send_req(32'h1800_0000, 1'b0);
      expect_frame(RJT_WORD, w, 5);
    end
    $display("test_reject_codes done");
  endtask

  // Invalid attachment overrides an accept and a vendor cause
  task automatic test_invalid_attach;
    inv = 1'b1;
    rc = CAUSE_VENDOR;
    ec = EXPL_NONE;
    vend = 8'h5C;
    send_req(32'h1000_0000, 1'b1);
    expect_frame(RJT_WORD, {RESERVED_BYTE, RSN_INVALID_ATT, EXP_NONE, 8'h00}, 5);
    inv = 1'b0;
    $display("test_invalid_attach done");
  endtask

  // Hello and link state requests get a pulse and no frame
  task automatic test_silent;
    logic [31:0] cmds [3];
    cmds = '{CMD_HELLO, CMD_LS_UPDATE, CMD_LS_ACK};
    for (int i = 0; i < 3; i++) begin
      send_req(cmds[i], 1'b1);
      check({32'h0, no_reply}, 33'h1);
      @(negedge clk);
      check({32'h0, no_reply}, 33'h0);
    end
    repeat (10) @(negedge clk);
    check(33'(sink_u.words.size()), 33'h0);
    $display("test_silent done");
  endtask

  // Sink stalls with the buffer full; no word may be lost or changed
  task automatic test_stall;
    logic [31:0] held;
    stall = 1'b1;
    rc = CAUSE_BUSY;
    ec = EXPL_IN_PROGRESS;
    send_req(32'h1700_0000, 1'b0);
    repeat (8) @(negedge clk);
    held = out_data;
    check({31'h0, out_valid, req_ready}, 33'h2);
    repeat (4) @(negedge clk);
    check({1'b0, out_data}, {1'b0, held});
    stall = 1'b0;
    slow = 1'b1;
    expect_frame(RJT_WORD, {RESERVED_BYTE, RSN_BUSY, EXP_IN_PROGRESS, 8'h00}, 5);
    slow = 1'b0;
    $display("test_stall done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (12) @(negedge clk);
    check({31'h0, req_ready, out_valid}, 33'h2);
    rst_n = 1'b1;
    test_accept;
    test_reject_codes;
    test_invalid_attach;
    test_silent;
    test_stall;
    stop_test;
  end

  // Cuts a hang well after the expected few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
